// ### rtl/flags_pkg.sv
// Shared types and constants of the condition flags block
package flags_pkg;

    // ****************************************************************
    // Widths and bit positions
    // ****************************************************************
    localparam int BYTE_W = 8;       // Byte width
    localparam int BYTE_MSB = 7;     // Sign bit of a byte
    localparam int WORD_MSB = 15;    // Sign bit of a word
    localparam int NIB_MSB = 3;      // Half-carry point of a byte
    localparam int WNIB_MSB = 11;    // Half-carry point of a word

    // ****************************************************************
    // Address constants
    // ****************************************************************
    localparam logic [15:0] PC_RESET = 16'h0000;  // Counter under reset
    localparam logic [15:0] VEC_ADDR = 16'h0000;  // Reset vector address
    localparam logic [15:0] PC_STEP = 16'h0002;   // One fetch word

    // Condition flags register layout, bit 7 down to bit 0
    typedef struct packed {
        logic i;    // Interrupt mask
        logic u6;   // User bit
        logic h;    // Half-carry
        logic u4;   // User bit
        logic n;    // Negative
        logic z;    // Zero
        logic v;    // Overflow
        logic c;    // Carry and bit accumulator
    } flags_t;

    // Operations that touch the flags
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_ADD = 5'h01,
        OP_ADD_WITH_CARRY_INSTR = 5'h02,
        OP_SUB = 5'h03,
        OP_SUBTRACT_WITH_BORROW_INSTR = 5'h04,
        OP_CMP = 5'h05,
        OP_NEG = 5'h06,
        OP_LOGIC = 5'h07,
        OP_SHLL = 5'h08,
        OP_SHLR = 5'h09,
        OP_ROTXL = 5'h0A,
        OP_ROTXR = 5'h0B,
        OP_BLD = 5'h0C,
        OP_BAND = 5'h0D,
        OP_BOR = 5'h0E,
        OP_BXOR = 5'h0F,
        OP_LDC = 5'h10,
        OP_AND_INTO_FLAGS_INSTR = 5'h11,
        OP_ORC = 5'h12,
        OP_XOR_INTO_FLAGS_INSTR = 5'h13,
        OP_RESTORE = 5'h14
    } op_t;

    // One completing instruction as seen by the flags
    typedef struct packed {
        op_t op;            // Operation
        logic word;         // Word size for add, subtract, compare and logic
        logic inv;          // Invert the bit operand
        logic bit_val;      // Selected bit for bit operations
        logic [15:0] a;     // First operand or logic result
        logic [15:0] b;     // Second operand
    } op_req_t;

    // Reset sequencer states
    typedef enum logic [0:0] {
        ST_VEC = 1'b0,
        ST_RUN = 1'b1
    } seq_t;

endpackage : flags_pkg

// ### rtl/flag_unit.sv
// Combinational flag and result computation for one instruction
`timescale 1ns/1ps
module flag_unit (
    input wire flags_pkg::op_req_t req_in,
    input wire flags_pkg::flags_t flags_in,
    output flags_pkg::flags_t upd_out,
    output flags_pkg::flags_t val_out,
    output logic [15:0] result_out
);
    import flags_pkg::*;

    // Sign bit at the chosen size
    function automatic logic top(input logic [15:0] x, input logic w);
        return w ? x[WORD_MSB] : x[BYTE_MSB];
    endfunction : top

    // All-zero test at the chosen size
    function automatic logic nil(input logic [15:0] x, input logic w);
        return w ? (x == 16'h0000) : (x[BYTE_MSB:0] == 8'h00);
    endfunction : nil

    logic sub;          // Subtracting operation
    logic wide;         // Word-sized arithmetic
    logic ci;           // Effective carry in
    logic bop;          // Bit operand after inversion
    logic [15:0] am;    // First adder input
    logic [15:0] be;    // Second adder input
    logic [16:0] full;  // Full sum
    logic [4:0] hb;     // Low nibble sum
    logic [12:0] hw;    // Low twelve-bit sum
    logic [15:0] res;   // Result

    // Adder path shared by add, subtract, compare and negate
    always_comb begin
        sub = req_in.op inside {OP_SUB, OP_SUBTRACT_WITH_BORROW_INSTR, OP_CMP, OP_NEG};
        wide = req_in.word && (req_in.op inside {OP_ADD, OP_SUB, OP_CMP});
        ci = (req_in.op inside {OP_ADD_WITH_CARRY_INSTR, OP_SUBTRACT_WITH_BORROW_INSTR}) ? flags_in.c : 1'b0;
        ci = sub ? ~ci : ci;
        am = (req_in.op == OP_NEG) ? 16'h0000 : req_in.a;
        be = (req_in.op == OP_NEG) ? req_in.a : req_in.b;
        be = sub ? ~be : be;
        if (!wide) begin
            am[WORD_MSB:BYTE_W] = 8'h00;
            be[WORD_MSB:BYTE_W] = 8'h00;
        end
        full = {1'b0, am} + {1'b0, be} + 17'(ci);
        hb = {1'b0, am[NIB_MSB:0]} + {1'b0, be[NIB_MSB:0]} + 5'(ci);
        hw = {1'b0, am[WNIB_MSB:0]} + {1'b0, be[WNIB_MSB:0]} + 13'(ci);
    end

    // Per-operation result and flag selection
    always_comb begin
        upd_out = '0;
        val_out = flags_in;
        res = req_in.a;
        bop = req_in.bit_val ^ req_in.inv;
        unique case (req_in.op)
            OP_ADD, OP_ADD_WITH_CARRY_INSTR, OP_SUB, OP_SUBTRACT_WITH_BORROW_INSTR, OP_CMP, OP_NEG: begin
                res = full[15:0];
                // Byte result: the adder carry must not leak into bit 8
                if (!wide) begin
                    res[WORD_MSB:BYTE_W] = 8'h00;
                end
                upd_out.h = 1'b1;
                upd_out.n = 1'b1;
                upd_out.z = 1'b1;
                upd_out.v = 1'b1;
                upd_out.c = 1'b1;
                // Carry or borrow out of the half point
                val_out.h = (wide ? hw[WNIB_MSB+1] : hb[NIB_MSB+1]) ^ sub;
                // Carry on add, borrow on subtract
                val_out.c = (wide ? full[WORD_MSB+1] : full[BYTE_W]) ^ sub;
                val_out.v = (top(am, wide) == top(be, wide))
                    && (top(res, wide) != top(am, wide));
                val_out.n = top(res, wide);
                val_out.z = nil(res, wide);
            end
            OP_LOGIC: begin
                // Logic result arrives ready; carry and half-carry kept
                if (!req_in.word) begin
                    res[WORD_MSB:BYTE_W] = 8'h00;
                end
                upd_out.n = 1'b1;
                upd_out.z = 1'b1;
                upd_out.v = 1'b1;
                val_out.n = top(res, req_in.word);
                val_out.z = nil(res, req_in.word);
                val_out.v = 1'b0;
            end
            OP_SHLL, OP_SHLR, OP_ROTXL, OP_ROTXR: begin
                upd_out.n = 1'b1;
                upd_out.z = 1'b1;
                upd_out.v = 1'b1;
                upd_out.c = 1'b1;
                res = 16'h0000;
                if (req_in.op inside {OP_SHLL, OP_ROTXL}) begin
                    res[BYTE_MSB:0] = {req_in.a[BYTE_MSB-1:0],
                        (req_in.op == OP_ROTXL) & flags_in.c};
                    val_out.c = req_in.a[BYTE_MSB];
                end else begin
                    res[BYTE_MSB:0] = {(req_in.op == OP_ROTXR) & flags_in.c,
                        req_in.a[BYTE_MSB:1]};
                    val_out.c = req_in.a[0];
                end
                val_out.n = res[BYTE_MSB];
                val_out.z = nil(res, 1'b0);
                val_out.v = 1'b0;
            end
            OP_BLD, OP_BAND, OP_BOR, OP_BXOR: begin
                // Carry acts as the one-bit accumulator
                upd_out.c = 1'b1;
                unique case (req_in.op)
                    OP_BLD: val_out.c = bop;
                    OP_BAND: val_out.c = flags_in.c & bop;
                    OP_BOR: val_out.c = flags_in.c | bop;
                    default: val_out.c = flags_in.c ^ bop;
                endcase
            end
            OP_LDC, OP_AND_INTO_FLAGS_INSTR, OP_ORC, OP_XOR_INTO_FLAGS_INSTR, OP_RESTORE: begin
                // Software transfers reach every bit, user bits too
                upd_out = '1;
                unique case (req_in.op)
                    OP_LDC: val_out = req_in.a[BYTE_MSB:0];
                    OP_AND_INTO_FLAGS_INSTR: val_out = flags_in & req_in.a[BYTE_MSB:0];
                    OP_ORC: val_out = flags_in | req_in.a[BYTE_MSB:0];
                    OP_XOR_INTO_FLAGS_INSTR: val_out = flags_in ^ req_in.a[BYTE_MSB:0];
                    // Restore takes the upper copy only
                    default: val_out = req_in.a[WORD_MSB:BYTE_W];
                endcase
            end
            default: begin
                res = req_in.a;
            end
        endcase
        result_out = res;
    end

endmodule : flag_unit

// ### rtl/vector_fetch.sv
// Reset sequencer that reads the first vector into the counter
`timescale 1ns/1ps
module vector_fetch (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ack_in,
    input wire logic [15:0] data_in,
    output logic rd_out,
    output logic load_out,
    output logic [15:0] pc_out,
    output logic run_out
);
    import flags_pkg::*;

    seq_t state_r;      // Sequencer state
    seq_t state_nxt;    // Next state

    // Next state: leave vector fetch once the read is answered
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_VEC: begin
                if (ack_in) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // State register, fetch of the vector follows every reset
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= ST_VEC;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rd_out = (state_r == ST_VEC);
    assign load_out = (state_r == ST_VEC) && ack_in;
    // Vector word lands with its low bit forced even
    assign pc_out = {data_in[WORD_MSB:1], 1'b0};
    assign run_out = (state_r == ST_RUN);

endmodule : vector_fetch

// ### rtl/condition_flags_reg.sv
// Condition flags register with mask, reset vector and counter
`timescale 1ns/1ps

// Function
// - Eight-bit register: mask, user bits, five flags
// - Reset sequence sets the mask bit
// - Reset leaves the other bits unset
// - Mask set blocks maskable interrupt acceptance
// - Every exception start sets the mask
// - Bits six and four are software user bits
// - Byte arithmetic: half-carry from bit three
// - Word arithmetic: half-carry from bit eleven
// - Negative flag takes the result sign
// - Zero flag set only for zero result
// - Overflow flag marks signed overflow only
// - Add sets carry on top carry
// - Subtract uses carry as borrow
// - Shifts load carry with the bit out
// - Carry is the bit-operation accumulator
// - Untouched flags keep their previous values
// - Reset loads counter from vector zero
// - Reset leaves general registers undefined
// - Word fetch, counter low bit zero
// - Push doubles the byte, restore uses upper
module condition_flags_reg (
    input wire logic CLOCK_IN,
    input wire logic RST_B_IN,
    input wire logic OP_VALID_IN,
    input wire flags_pkg::op_req_t OP_REQ_IN,
    input wire logic EXC_START_IN,
    input wire logic IRQ_REQ_IN,
    input wire logic VEC_ACK_IN,
    input wire logic [15:0] VEC_DATA_IN,
    input wire logic PC_WR_IN,
    input wire logic [15:0] PC_WR_DATA_IN,
    input wire logic FETCH_NEXT_IN,
    output flags_pkg::flags_t FLAGS_OUT,
    output logic [15:0] PUSH_WORD_OUT,
    output logic [15:0] RESULT_OUT,
    output logic IRQ_TAKE_OUT,
    output logic VEC_RD_OUT,
    output logic [15:0] VEC_ADDR_OUT,
    output logic [15:0] PC_OUT,
    output logic RUN_OUT
);
    import flags_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic i_r;              // Interrupt mask bit
    logic i_nxt;            // Next mask bit
    logic [6:0] low_r;      // Bits six to zero, never reset
    logic [6:0] low_nxt;    // Next value of the low bits
    flags_t flags;          // Whole register view
    flags_t upd;            // Bits the instruction writes
    flags_t val;            // Values the instruction offers
    flags_t merged;         // Register after the update
    logic [15:0] res;       // Result from the flag unit
    logic [15:0] res_r;     // Registered result
    logic [15:0] res_nxt;   // Next result
    logic [15:0] pc_r;      // Program counter
    logic [15:0] pc_nxt;    // Next program counter
    logic [15:0] vec_pc;    // Counter value from the vector
    logic vec_load;         // Vector read answered
    logic running;          // Reset sequence done
    logic take;             // Instruction completes this cycle

    // ****************************************************************
    // Submodules
    // ****************************************************************

    // Result and flag computation
    flag_unit u_flag_unit (
        .req_in(OP_REQ_IN),
        .flags_in(flags),
        .upd_out(upd),
        .val_out(val),
        .result_out(res)
    );

    // Reset vector fetch
    vector_fetch u_vector_fetch (
        .clk_in(CLOCK_IN),
        .rst_b_in(RST_B_IN),
        .ack_in(VEC_ACK_IN),
        .data_in(VEC_DATA_IN),
        .rd_out(VEC_RD_OUT),
        .load_out(vec_load),
        .pc_out(vec_pc),
        .run_out(running)
    );

    // ****************************************************************
    // Condition flags
    // ****************************************************************

    assign flags = {i_r, low_r};
    assign take = OP_VALID_IN && running;

    // Merge: only written bits change, the rest are held
    always_comb begin
        merged = (flags & ~upd) | (val & upd);
        low_nxt = low_r;
        i_nxt = i_r;
        if (take) begin
            low_nxt = merged[6:0];
            i_nxt = merged.i;
        end
        // Exception start wins over a software clear
        if (EXC_START_IN || !running) begin
            i_nxt = 1'b1;
        end
    end

    // Mask bit comes out of reset set
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            i_r <= 1'b1;
        end else begin
            i_r <= i_nxt;
        end
    end

    // Low bits have no reset; they start undefined
    always_ff @(posedge CLOCK_IN) begin
        low_r <= low_nxt;
    end

    // Maskable interrupt taken only while the mask is clear
    assign IRQ_TAKE_OUT = IRQ_REQ_IN && !i_r && running;

    assign FLAGS_OUT = flags;
    // Two identical copies make the stacked word
    assign PUSH_WORD_OUT = {flags, flags};

    // ****************************************************************
    // Result register
    // ****************************************************************

    // Capture the result of each completing instruction
    always_comb begin
        res_nxt = res_r;
        if (take) begin
            res_nxt = res;
        end
    end

    // Result holds until the next completion
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            res_r <= 16'h0000;
        end else begin
            res_r <= res_nxt;
        end
    end

    assign RESULT_OUT = res_r;

    // ****************************************************************
    // Program counter
    // ****************************************************************

    // Vector load, jump or one word step; low bit always zero
    always_comb begin
        pc_nxt = pc_r;
        if (vec_load) begin
            pc_nxt = vec_pc;
        end else if (running && PC_WR_IN) begin
            pc_nxt = {PC_WR_DATA_IN[WORD_MSB:1], 1'b0};
        end else if (running && FETCH_NEXT_IN) begin
            pc_nxt = pc_r + PC_STEP;
        end
    end

    // General registers and stack pointer live outside; reset
    // puts nothing into them
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pc_r <= PC_RESET;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    assign PC_OUT = pc_r;
    assign VEC_ADDR_OUT = VEC_ADDR;
    assign RUN_OUT = running;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    logic [4:0] nib_sum;    // Byte half-carry reference
    logic [12:0] w12_sum;   // Word half-carry reference
    logic [8:0] byte_sum;   // Byte add reference
    logic byte_ovf;         // Byte add overflow reference
    logic byte_brw;         // Byte subtract borrow reference
    logic add_b;            // Byte add completes
    logic add_w;            // Word add completes
    logic sub_b;            // Byte subtract completes
    logic logic_b;          // Byte logic result completes
    logic known_r;          // Every flag bit written since reset
    logic known_nxt;        // Next value of the written marker

    // Reference arithmetic beside the flag unit
    always_comb begin
        nib_sum = {1'b0, OP_REQ_IN.a[NIB_MSB:0]}
            + {1'b0, OP_REQ_IN.b[NIB_MSB:0]};
        w12_sum = {1'b0, OP_REQ_IN.a[WNIB_MSB:0]}
            + {1'b0, OP_REQ_IN.b[WNIB_MSB:0]};
        byte_sum = {1'b0, OP_REQ_IN.a[BYTE_MSB:0]}
            + {1'b0, OP_REQ_IN.b[BYTE_MSB:0]};
        byte_ovf = (OP_REQ_IN.a[BYTE_MSB] == OP_REQ_IN.b[BYTE_MSB])
            && (byte_sum[BYTE_MSB] != OP_REQ_IN.a[BYTE_MSB]);
        byte_brw = OP_REQ_IN.a[BYTE_MSB:0] < OP_REQ_IN.b[BYTE_MSB:0];
        add_b = take && OP_REQ_IN.op == OP_ADD && !OP_REQ_IN.word;
        add_w = take && OP_REQ_IN.op == OP_ADD && OP_REQ_IN.word;
        sub_b = take && OP_REQ_IN.op == OP_SUB && !OP_REQ_IN.word;
        logic_b = take && OP_REQ_IN.op == OP_LOGIC && !OP_REQ_IN.word;
        // Low bits start undefined; a full load gives them values
        known_nxt = known_r
            || (take && OP_REQ_IN.op inside {OP_LDC, OP_RESTORE});
    end

    // Marker of a full software load, so hold checks skip unknowns
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            known_r <= 1'b0;
        end else begin
            known_r <= known_nxt;
        end
    end

    a_mask_while_seq: assert property (!running |=> i_r)
        else $error("mask bit clear during reset sequence");
    a_mask_blocks_irq: assert property (i_r |-> !IRQ_TAKE_OUT)
        else $error("interrupt taken while masked");
    a_exc_sets_mask: assert property (EXC_START_IN |=> i_r)
        else $error("exception start left mask clear");
    a_user_bit_load: assert property (take && OP_REQ_IN.op == OP_LDC
        |=> FLAGS_OUT.u6 == $past(OP_REQ_IN.a[6])
        && FLAGS_OUT.u4 == $past(OP_REQ_IN.a[4]))
        else $error("user bits not loaded");
    a_half_byte_add: assert property (add_b
        |=> FLAGS_OUT.h == $past(nib_sum[NIB_MSB+1]))
        else $error("byte half-carry wrong");
    a_half_word_add: assert property (add_w
        |=> FLAGS_OUT.h == $past(w12_sum[WNIB_MSB+1]))
        else $error("word half-carry wrong");
    a_neg_sign_bit: assert property (logic_b
        |=> FLAGS_OUT.n == RESULT_OUT[BYTE_MSB])
        else $error("negative flag differs from sign");
    a_zero_result: assert property (logic_b
        |=> FLAGS_OUT.z == (RESULT_OUT[BYTE_MSB:0] == 8'h00))
        else $error("zero flag wrong");
    a_ovf_byte_add: assert property (add_b
        |=> FLAGS_OUT.v == $past(byte_ovf))
        else $error("overflow flag wrong");
    a_carry_byte_add: assert property (add_b
        |=> FLAGS_OUT.c == $past(byte_sum[BYTE_W]))
        else $error("add carry wrong");
    a_borrow_byte_sub: assert property (sub_b
        |=> FLAGS_OUT.c == $past(byte_brw))
        else $error("subtract borrow wrong");
    a_shift_carry_out: assert property (take && OP_REQ_IN.op == OP_SHLL
        |=> FLAGS_OUT.c == $past(OP_REQ_IN.a[BYTE_MSB]))
        else $error("shift carry wrong");
    a_bit_acc_load: assert property (take && OP_REQ_IN.op == OP_BLD
        |=> FLAGS_OUT.c == $past(OP_REQ_IN.bit_val ^ OP_REQ_IN.inv))
        else $error("bit load into carry wrong");
    a_keep_carry: assert property (logic_b
        |=> FLAGS_OUT.c == $past(FLAGS_OUT.c)
        && FLAGS_OUT.h == $past(FLAGS_OUT.h))
        else $error("untouched flag changed");
    a_pc_from_vector: assert property (VEC_RD_OUT && VEC_ACK_IN
        |=> PC_OUT == {$past(VEC_DATA_IN[WORD_MSB:1]), 1'b0} && RUN_OUT)
        else $error("counter not loaded from vector");
    a_pc_even: assert property (FETCH_NEXT_IN && running && !PC_WR_IN
        |=> PC_OUT == $past(PC_OUT) + PC_STEP && !PC_OUT[0])
        else $error("fetch step or parity wrong");
    a_push_copies: assert property (PUSH_WORD_OUT
        == {FLAGS_OUT, FLAGS_OUT})
        else $error("pushed copies differ");
    a_restore_upper: assert property (take && OP_REQ_IN.op == OP_RESTORE
        |=> FLAGS_OUT[6:0] == $past(OP_REQ_IN.a[14:8]))
        else $error("restore did not use upper byte");
    a_idle_holds: assert property (known_r && running
        && !OP_VALID_IN && !EXC_START_IN
        |=> FLAGS_OUT == $past(FLAGS_OUT))
        else $error("flags changed without an instruction");

    c_byte_add: cover property (add_b);
    c_exception: cover property (EXC_START_IN && !i_r);
    c_vector_load: cover property (vec_load);
    c_irq_taken: cover property (IRQ_TAKE_OUT);

endmodule : condition_flags_reg

// ### test/tb_condition_flags_reg.sv
// Self-checking bench for the condition flags register
`timescale 1ns/1ps
module tb_condition_flags_reg;
    import flags_pkg::*;
    // ****************************************************************
    // Stimulus, observed outputs and score
    // ****************************************************************
    logic clock_in = 0, rst_b_in = 0, op_valid_in = 0, exc_start_in = 0;
    logic irq_req_in = 0, vec_ack_in = 0, pc_wr_in = 0, fetch_next_in = 0;
    logic [15:0] vec_data_in = 0, pc_wr_data_in = 0, v;
    op_req_t op_req_in = '0;
    flags_t flags_out;
    logic [15:0] push_word_out, result_out, vec_addr_out, pc_out;
    logic irq_take_out, vec_rd_out, run_out;
    logic [7:0] ef;  // Expected register
    logic [15:0] er;  // Expected result
    bit rk;  // Result is defined for the last operation
    int err_total = 0, checks = 0;
    condition_flags_reg DUT (.CLOCK_IN(clock_in), .RST_B_IN(rst_b_in),
        .OP_VALID_IN(op_valid_in), .OP_REQ_IN(op_req_in),
        .EXC_START_IN(exc_start_in), .IRQ_REQ_IN(irq_req_in),
        .VEC_ACK_IN(vec_ack_in), .VEC_DATA_IN(vec_data_in),
        .PC_WR_IN(pc_wr_in), .PC_WR_DATA_IN(pc_wr_data_in),
        .FETCH_NEXT_IN(fetch_next_in), .FLAGS_OUT(flags_out),
        .PUSH_WORD_OUT(push_word_out), .RESULT_OUT(result_out),
        .IRQ_TAKE_OUT(irq_take_out), .VEC_RD_OUT(vec_rd_out),
        .VEC_ADDR_OUT(vec_addr_out), .PC_OUT(pc_out), .RUN_OUT(run_out));
    always #20 clock_in = ~clock_in;
    // ****************************************************************
    // Compare, verdict and reference model
    // ****************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    function automatic void model(op_req_t q);
        int w, m, h, a, b, c, r, s;
        logic [7:0] f;
        f = ef;
        w = (q.word && q.op inside {OP_ADD, OP_SUB, OP_CMP, OP_LOGIC}) ? 16 : 8;
        m = (1 << w) - 1;
        h = m >> 4;
        a = q.a & m;
        b = q.b & m;
        c = (q.op inside {OP_ADD_WITH_CARRY_INSTR, OP_SUBTRACT_WITH_BORROW_INSTR}) ? f[0] : 0;
        s = q.op inside {OP_ADD, OP_ADD_WITH_CARRY_INSTR};
        if (q.op == OP_NEG) begin
            b = a;
            a = 0;
        end
        r = s ? a + b + c : a - b - c;
        case (q.op)
            OP_ADD, OP_ADD_WITH_CARRY_INSTR, OP_SUB, OP_SUBTRACT_WITH_BORROW_INSTR, OP_CMP, OP_NEG: begin
                f[5] = s ? ((a & h) + (b & h) + c) >> (w - 4)
                    : (a & h) < (b & h) + c;
                f[0] = s ? r >> w : a < b + c;
                r = r & m;
                f[1] = ((a ^ r) & (s ? ~(a ^ b) : a ^ b)) >> (w - 1) & 1;
            end
            OP_LOGIC: r = a;
            OP_SHLL: {f[0], r} = {a[7], a << 1};
            OP_SHLR: {f[0], r} = {a[0], a >> 1};
            OP_ROTXL: {f[0], r} = {a[7], (a << 1) | f[0]};
            OP_ROTXR: {f[0], r} = {a[0], (a >> 1) | (f[0] << 7)};
            OP_BLD: f[0] = q.bit_val ^ q.inv;
            OP_BAND: f[0] &= q.bit_val ^ q.inv;
            OP_BOR: f[0] |= q.bit_val ^ q.inv;
            OP_BXOR: f[0] ^= q.bit_val ^ q.inv;
            OP_LDC: f = q.a[7:0];
            OP_AND_INTO_FLAGS_INSTR: f &= q.a[7:0];
            OP_ORC: f |= q.a[7:0];
            OP_XOR_INTO_FLAGS_INSTR: f ^= q.a[7:0];
            OP_RESTORE: f = q.a[15:8];
            default: ;
        endcase
        rk = q.op inside {[OP_ADD:OP_ROTXR]} && q.op != OP_CMP;
        if (q.op inside {[OP_ADD:OP_ROTXR]}) begin
            r = r & m;
            f[1] = (q.op >= OP_LOGIC) ? 1'b0 : f[1];
            f[3] = r >> (w - 1) & 1;
            f[2] = r == 0;
            er = r;
        end
        ef = f;
    endfunction : model
    // One completing instruction with optional exception start
    task automatic run_op(input op_t op, input logic w, e,
                          input logic [15:0] a, b);
        op_req_t q;
        q = '{op: op, word: w, inv: b[1], bit_val: b[0], a: a, b: b};
        @(posedge clock_in);
        op_valid_in <= 1'b1;
        op_req_in <= q;
        exc_start_in <= e;
        irq_req_in <= 1'($urandom);
        @(posedge clock_in);
        op_valid_in <= 1'b0;
        exc_start_in <= 1'b0;
        model(q);
        ef[7] = ef[7] | e;
        #1;
        chk(flags_out, ef);
        chk(push_word_out, {ef, ef});
        chk(irq_take_out, irq_req_in & ~ef[7]);
        if (rk) chk(result_out, er);
    endtask : run_op
    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        void'($urandom(32'hE7E03A17));
        v = 16'($urandom) | 16'h0001;
        repeat (3) @(posedge clock_in);
        #1 chk(flags_out.i, 1'b1);
        chk({vec_rd_out, run_out}, 2'b10);
        chk(vec_addr_out, 16'h0000);
        @(posedge clock_in);
        rst_b_in <= 1'b1;
        pc_wr_in <= 1'b1;
        pc_wr_data_in <= 16'h1234;
        @(posedge clock_in);
        pc_wr_in <= 1'b0;
        vec_ack_in <= 1'b1;
        vec_data_in <= v;
        @(posedge clock_in);
        vec_ack_in <= 1'b0;
        vec_data_in <= ~v;
        fetch_next_in <= 1'b1;
        #1 chk(pc_out, v & 16'hFFFE);
        chk({vec_rd_out, run_out, flags_out.i}, 3'h3);
        @(posedge clock_in);
        pc_wr_in <= 1'b1;
        pc_wr_data_in <= 16'h5A5B;
        #1 chk(pc_out, (v & 16'hFFFE) + 16'h0002);
        @(posedge clock_in);
        {pc_wr_in, fetch_next_in} <= 2'b00;
        #1 chk(pc_out, 16'h5A5A);
        // First instruction gives every undefined bit a value
        run_op(OP_LDC, 1'b0, 1'b0, 16'h005A, 16'h0000);
        run_op(OP_LDC, 1'b0, 1'b1, 16'h0000, 16'h0000);
        repeat (300) run_op(op_t'($urandom_range(0, 20)), 1'($urandom),
            $urandom_range(0, 15) == 0, 16'($urandom), 16'($urandom));
        stop_test();
    end
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
endmodule : tb_condition_flags_reg
